// file: phy_regs_pkg.sv
// Register offsets, field positions and reset values of the PHY MII status/advert bank
package phy_regs_pkg;

   // ------------------------------------------------------------
   // Host bus shape
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // ------------------------------------------------------------
   // Register offsets (byte addresses of 16-bit words)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BASIC_STATUS = 8'hE6;
   localparam logic [7:0] OFS_ID_LOW = 8'hE8;
   localparam logic [7:0] OFS_ID_HIGH = 8'hEA;
   localparam logic [7:0] OFS_AUTONEG_ADV = 8'hEC;
   localparam logic [7:0] OFS_LP_ABILITY = 8'hEE;
   localparam logic [7:0] OFS_PORT_CONTROL = 8'hF6;
   localparam logic [7:0] OFS_PORT_STATUS = 8'hF8;

   // ------------------------------------------------------------
   // Basic status fields
   // ------------------------------------------------------------
   localparam int ST_T4_BIT = 15;
   localparam int ST_100FD_BIT = 14;
   localparam int ST_100HD_BIT = 13;
   localparam int ST_10FD_BIT = 12;
   localparam int ST_10HD_BIT = 11;
   localparam int ST_AN_DONE_BIT = 5;
   localparam int ST_AN_CAP_BIT = 3;
   localparam int ST_LINK_BIT = 2;
   localparam int ST_EXT_BIT = 0;
   localparam logic ST_T4_VAL = 1'b0;
   localparam logic ST_CAP_VAL = 1'b1;
   localparam logic ST_EXT_VAL = 1'b0;

   // ------------------------------------------------------------
   // Advertisement and link partner fields (same layout)
   // ------------------------------------------------------------
   localparam int ADV_PAUSE_BIT = 10;
   localparam int ADV_100FD_BIT = 8;
   localparam int ADV_100HD_BIT = 7;
   localparam int ADV_10FD_BIT = 6;
   localparam int ADV_10HD_BIT = 5;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;

   // ------------------------------------------------------------
   // Port control / port status fields
   // ------------------------------------------------------------
   localparam int PC_PAUSE_BIT = 4;
   localparam int PC_100FD_BIT = 3;
   localparam int PC_100HD_BIT = 2;
   localparam int PC_10FD_BIT = 1;
   localparam int PC_10HD_BIT = 0;
   localparam int PS_AN_DONE_BIT = 6;
   localparam logic [4:0] ADV_RESET = 5'h1F;

   // ------------------------------------------------------------
   // Synchroniser depth
   // ------------------------------------------------------------
   localparam int SYNC_STAGES = 2;

endpackage

// file: level_sync.sv
// Two-flop level synchroniser for PHY status inputs
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // Core clock
   input wire logic rst_b, // Async reset, active low
   input wire logic [WIDTH-1:0] d, // Asynchronous level
   output var logic [WIDTH-1:0] q // Synchronised level
);
   logic [WIDTH-1:0] meta_reg;

   // ------------------------------------------------------------
   // Stages: first flop feeds only the second
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// file: phy_mii_status_id_advert_regs.sv
// PHY MII basic status, identifier and auto-negotiation advertisement register bank
// Function
// R1: Status bit 15 reads 0: no 100BASE-T4 operation.
// R2: Status bits 14 and 13 read 1: 100BASE-TX full and half duplex.
// R3: Status bits 12 and 11 read 1: 10BASE-T full and half duplex.
// R4: Status bit 0 reads 0: no extended register set.
// R5: Status bit 5 shows auto-negotiation done, same as port status bit 6.
// R6: Status bit 3 shows whether auto-negotiation is supported.
// R7: Identifier low word is a read-only 16-bit value.
// R8: Identifier high word is a read-only 16-bit value.
// R9: Advert bit 10 offers pause, resets 1, shared with port control bit 4.
// R10: Advert bit 8 offers 100 full, resets 1, shared with port control bit 3.
// R11: Advert bit 7 offers 100 half, resets 1, shared with port control bit 2.
// R12: Advert bit 6 offers 10 full, shared with port control bit 1.
// R13: Advert bit 5 offers 10 half, resets 1, shared with port control bit 0.
// R14: Advert selector reads 0x01; bits 15 to 11 and 9 read zero.
// R15: Shared bits are one storage; writes show at once in both views.
// R16: Partner ability is read-only; bit 8 mirrors port status bit 3.
`timescale 1ns/1ps
`default_nettype none
module phy_mii_status_id_advert_regs
   import phy_regs_pkg::*;
#(
   parameter logic AN_CAPABLE = 1'b1,
   parameter logic [15:0] ID_LOW = 16'h0A5C, // Arbitrary value
   parameter logic [15:0] ID_HIGH = 16'h00C3 // Arbitrary value
) (
   input wire logic clk, // Core clock, 50 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic [phy_regs_pkg::ADDR_W-1:0] addr, // Byte address of a word
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   input wire logic [1:0] be, // Byte enables
   input wire logic [phy_regs_pkg::DATA_W-1:0] wdata, // Write data
   output var logic [phy_regs_pkg::DATA_W-1:0] rd_data, // Read data, held
   output var logic rd_valid, // Read data pulse
   input wire logic an_complete_in, // Auto-negotiation done, PHY side
   input wire logic link_up_in, // Link up, PHY side
   input wire logic [4:0] lp_ability_in, // Partner pause,100F,100H,10F,10H
   output var logic [4:0] adv_ability // Advertised pause,100F,100H,10F,10H
);
   import phy_regs_pkg::*;

   logic an_sync;
   logic link_sync;
   logic [4:0] lp_sync;
   logic [DATA_W-1:0] read_word;

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   level_sync #(.WIDTH(7)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({an_complete_in, link_up_in, lp_ability_in}),
      .q({an_sync, link_sync, lp_sync})
   );

   // ------------------------------------------------------------
   // Word builders
   // ------------------------------------------------------------
   function automatic logic [15:0] ability_word(input logic [4:0] ab, input logic [4:0] sel);
      logic [15:0] w;
      w = 16'h0000;
      w[ADV_PAUSE_BIT] = ab[PC_PAUSE_BIT];
      w[ADV_100FD_BIT] = ab[PC_100FD_BIT];
      w[ADV_100HD_BIT] = ab[PC_100HD_BIT];
      w[ADV_10FD_BIT] = ab[PC_10FD_BIT];
      w[ADV_10HD_BIT] = ab[PC_10HD_BIT];
      w[4:0] = sel;
      return w;
   endfunction

   function automatic logic [15:0] status_word(input logic an_done, input logic link);
      logic [15:0] w;
      w = 16'h0000;
      w[ST_T4_BIT] = ST_T4_VAL; // R1
      w[ST_100FD_BIT] = ST_CAP_VAL; // R2
      w[ST_100HD_BIT] = ST_CAP_VAL; // R2
      w[ST_10FD_BIT] = ST_CAP_VAL; // R3
      w[ST_10HD_BIT] = ST_CAP_VAL; // R3
      w[ST_AN_DONE_BIT] = an_done; // R5
      w[ST_AN_CAP_BIT] = AN_CAPABLE; // R6
      w[ST_LINK_BIT] = link;
      w[ST_EXT_BIT] = ST_EXT_VAL; // R4
      return w;
   endfunction

   // ------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------
   always_comb begin
      read_word = 16'h0000;
      case ({addr[7:1], 1'b0})
         OFS_BASIC_STATUS: read_word = status_word(an_sync, link_sync);
         OFS_ID_LOW: read_word = ID_LOW; // R7
         OFS_ID_HIGH: read_word = ID_HIGH; // R8
         OFS_AUTONEG_ADV: read_word = ability_word(adv_ability, ADV_SELECTOR); // R14
         OFS_LP_ABILITY: read_word = ability_word(lp_sync, ADV_SELECTOR); // R16
         OFS_PORT_CONTROL: read_word = {11'h000, adv_ability}; // R15
         OFS_PORT_STATUS: begin
            read_word[PS_AN_DONE_BIT] = an_sync; // R5
            read_word[4:0] = lp_sync; // R16
         end
         default: read_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= read_word;
         end
      end
   end

   // ------------------------------------------------------------
   // Shared advertisement storage
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adv_ability <= ADV_RESET; // R9 R10 R11 R12 R13
      end else if (wr_en) begin
         if ({addr[7:1], 1'b0} == OFS_AUTONEG_ADV) begin
            if (be[1]) begin
               adv_ability[PC_PAUSE_BIT] <= wdata[ADV_PAUSE_BIT]; // R9
               adv_ability[PC_100FD_BIT] <= wdata[ADV_100FD_BIT]; // R10
            end
            if (be[0]) begin
               adv_ability[PC_100HD_BIT] <= wdata[ADV_100HD_BIT]; // R11
               adv_ability[PC_10FD_BIT] <= wdata[ADV_10FD_BIT]; // R12
               adv_ability[PC_10HD_BIT] <= wdata[ADV_10HD_BIT]; // R13
            end
         end else if ({addr[7:1], 1'b0} == OFS_PORT_CONTROL && be[0]) begin
            adv_ability <= wdata[4:0]; // R15
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   wire rd_stat = rd_en && {addr[7:1], 1'b0} == OFS_BASIC_STATUS;
   wire rd_adv = rd_en && {addr[7:1], 1'b0} == OFS_AUTONEG_ADV;
   wire rd_lpa = rd_en && {addr[7:1], 1'b0} == OFS_LP_ABILITY;
   wire wr_pc = wr_en && be[0] && {addr[7:1], 1'b0} == OFS_PORT_CONTROL;
   wire wr_adv_hi = wr_en && be[1] && {addr[7:1], 1'b0} == OFS_AUTONEG_ADV;

   t4_bit_a: assert property (rd_stat |=> rd_valid && !rd_data[15]) // R1
      else $error("status bit 15 not zero");
   tx_caps_a: assert property (rd_stat |=> rd_data[14:13] == 2'b11) // R2
      else $error("100BASE-TX capability bits wrong");
   ten_caps_a: assert property (rd_stat |=> rd_data[12:11] == 2'b11) // R3
      else $error("10BASE-T capability bits wrong");
   ext_bit_a: assert property (rd_stat |=> !rd_data[0]) // R4
      else $error("extended capable bit not zero");
   an_done_a: assert property (rd_stat |=> rd_data[5] == $past(an_sync)) // R5
      else $error("status bit 5 does not follow auto-negotiation done");
   an_cap_a: assert property (rd_stat |=> rd_data[3] == AN_CAPABLE) // R6
      else $error("auto-negotiation capable bit wrong");
   id_low_a: assert property ( // R7
      rd_en && {addr[7:1], 1'b0} == OFS_ID_LOW |=> rd_data == ID_LOW)
      else $error("identifier low word wrong");
   id_high_a: assert property ( // R8
      rd_en && {addr[7:1], 1'b0} == OFS_ID_HIGH |=> rd_data == ID_HIGH)
      else $error("identifier high word wrong");
   pause_write_a: assert property (wr_adv_hi |=> adv_ability[4] == $past(wdata[10])) // R9
      else $error("pause advert bit not written");
   adv_view_a: assert property (rd_adv |=> rd_data[8:5] == $past(adv_ability[3:0])) // R10
      else $error("advert view does not match shared storage");
   selector_a: assert property ( // R14
      rd_adv |=> rd_data[4:0] == 5'h01 && rd_data[15:11] == 5'h00 && !rd_data[9])
      else $error("advert fixed fields wrong");
   shared_store_a: assert property ( // R15
      wr_pc ##1 rd_adv |=> rd_data[8:5] == $past(wdata[3:0], 2))
      else $error("port control write not seen in advert view");
   lp_mirror_a: assert property (rd_lpa |=> rd_data[8] == $past(lp_sync[3])) // R16
      else $error("partner 100 full bit does not mirror port status");

endmodule
`default_nettype wire

// file: phy_side_model.sv
// Far-side PHY model: holds the status levels the PHY reports to the bank
`timescale 1ns/1ps
`default_nettype none
module phy_side_model (
   input wire logic clk, // Core clock
   input wire logic load, // Take new levels
   input wire logic [6:0] lvl, // {an done, link, partner abilities}
   output var logic an_complete_in, // Auto-negotiation done level
   output var logic link_up_in, // Link level
   output var logic [4:0] lp_ability_in // Partner pause,100F,100H,10F,10H
);
   // Levels move off the rising edge, as an unrelated PHY would
   always @(negedge clk) begin
      if (load) begin
         {an_complete_in, link_up_in, lp_ability_in} <= lvl;
      end
   end
endmodule
`default_nettype wire

// file: phy_mii_status_id_advert_regs_tb_top.sv
// Self-checking bench for the PHY status, identifier and advertisement bank
`timescale 1ns/1ps
`default_nettype none
module phy_mii_status_id_advert_regs_tb_top;
   import phy_regs_pkg::*;
   localparam logic [15:0] ID_LO = 16'h5A3C; // Arbitrary value
   localparam logic [15:0] ID_HI = 16'h0B71; // Arbitrary value
   logic clk, rst_b, wr_en, rd_en, load, rd_valid, an_i, link_i, an_m, link_m;
   logic [7:0] addr;
   logic [1:0] be;
   logic [15:0] wdata, rd_data;
   logic [4:0] lp_i, adv_ability, lp_m, adv_m;
   logic [6:0] lvl;
   integer seed = 32'hD1403929;
   int error_cnt = 0;
   int checked = 0;
   logic [7:0] tbl [8] = '{8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hED, 8'hEE, 8'hF6, 8'hF8};

   phy_mii_status_id_advert_regs #(.AN_CAPABLE(1'b1), .ID_LOW(ID_LO), .ID_HIGH(ID_HI)) i_dut (
      .clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .be(be),
      .wdata(wdata), .rd_data(rd_data), .rd_valid(rd_valid), .an_complete_in(an_i),
      .link_up_in(link_i), .lp_ability_in(lp_i), .adv_ability(adv_ability));
   phy_side_model i_phy (.clk(clk), .load(load), .lvl(lvl), .an_complete_in(an_i),
      .link_up_in(link_i), .lp_ability_in(lp_i));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Reference model and access tasks
   // ------------------------------------------------------------
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [15:0] expv(input logic [7:0] a);
      case ({a[7:1], 1'b0})
         OFS_BASIC_STATUS: return {10'h1E0, an_m, 2'h1, link_m, 2'h0};
         OFS_ID_LOW: return ID_LO;
         OFS_ID_HIGH: return ID_HI;
         OFS_AUTONEG_ADV: return {5'h00, adv_m[4], 1'b0, adv_m[3:0], ADV_SELECTOR};
         OFS_LP_ABILITY: return {5'h00, lp_m[4], 1'b0, lp_m[3:0], ADV_SELECTOR};
         OFS_PORT_CONTROL: return {11'h000, adv_m};
         OFS_PORT_STATUS: return {9'h000, an_m, 1'b0, lp_m};
         default: return 16'h0000;
      endcase
   endfunction

   // One bus cycle; a read in the same cycle as a write sees the old value
   task automatic acc(input logic r, input logic w, input logic [7:0] a,
                      input logic [1:0] b, input logic [15:0] d);
      logic [15:0] e;
      @(negedge clk);
      check({16'h0000, rd_valid}, 17'h00000);
      e = expv(a);
      addr = a;
      be = b;
      wdata = d;
      rd_en = r;
      wr_en = w;
      @(negedge clk);
      rd_en = 1'b0;
      wr_en = 1'b0;
      if (w && {a[7:1], 1'b0} == OFS_AUTONEG_ADV) begin
         if (b[1]) {adv_m[4], adv_m[3]} = {d[10], d[8]};
         if (b[0]) adv_m[2:0] = d[7:5];
      end
      if (w && {a[7:1], 1'b0} == OFS_PORT_CONTROL && b[0]) adv_m = d[4:0];
      if (r) check({rd_valid, rd_data}, {1'b1, e});
      check({12'h000, adv_ability}, {12'h000, adv_m});
   endtask

   // New PHY levels, then time for the two-flop synchronisers
   task automatic phy(input logic [6:0] v);
      @(negedge clk);
      lvl <= v;
      load <= 1'b1;
      @(negedge clk);
      load <= 1'b0;
      repeat (3) @(negedge clk);
      {an_m, link_m, lp_m} = v;
   endtask

   // Port control write, then advert read on the very next edge
   task automatic b2b(input logic [15:0] d);
      @(negedge clk);
      {addr, be, wdata, wr_en} = {OFS_PORT_CONTROL, 2'h1, d, 1'b1};
      @(negedge clk);
      adv_m = d[4:0];
      {addr, wr_en, rd_en} = {OFS_AUTONEG_ADV, 1'b0, 1'b1};
      @(negedge clk);
      rd_en = 1'b0;
      check({rd_valid, rd_data}, {1'b1, expv(OFS_AUTONEG_ADV)});
      check({12'h000, adv_ability}, {12'h000, adv_m});
   endtask

   task wrap_up;
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r, d;
      logic [7:0] a;
      // Model loads idle levels until the first phy call
      {rst_b, wr_en, rd_en, load} = 4'h1;
      {addr, be, wdata, lvl} = 33'h0;
      {an_m, link_m, lp_m} = 7'h00;
      adv_m = ADV_RESET;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      check({12'h000, adv_ability}, 17'h0001F);
      foreach (tbl[i]) acc(1'b1, 1'b0, tbl[i], 2'h0, 16'h0000);
      phy(7'h7F);
      for (int n = 0; n < 400; n++) begin
         r = $random(seed);
         d = $random(seed);
         a = r[3] ? tbl[r[2:0]] : r[15:8];
         if (r[17:16] == 2'h3 && r[27]) b2b(d[15:0]);
         else if (r[17:16] == 2'h3) phy(r[24:18]);
         else acc(r[17:16] != 2'h1, r[17:16] != 2'h0, a, r[26:25], d[15:0]);
      end
      // Mid-run reset: written advert bits return to their reset values
      @(negedge clk);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      adv_m = ADV_RESET;
      check({12'h000, adv_ability}, 17'h0001F);
      repeat (2) @(negedge clk);
      foreach (tbl[i]) acc(1'b1, 1'b0, tbl[i], 2'h0, 16'h0000);
      wrap_up;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      wrap_up;
   end
endmodule
`default_nettype wire
